// ===== common/scrb_pkg.sv
// Package for the sensor configuration register bank: register indices,
// control bit positions, reset values and access-port widths.
// Assumes one clock and a synchronous, active-high reset in the user module.
package scrb_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BANK_N = 24;
  localparam int unsigned IDX_W  = 5;

  typedef logic [ADDR_W-1:0] scrb_addr_t;
  typedef logic [DATA_W-1:0] scrb_data_t;
  typedef logic [IDX_W-1:0]  scrb_idx_t;

  // ==========================================================================
  // Register addresses (byte offsets on the serial register map)
  // ==========================================================================
  localparam scrb_addr_t ADDR_PRESSURE_TARGET_HIGH     = 8'h16;
  localparam scrb_addr_t ADDR_PRESSURE_TARGET_LOW      = 8'h17;
  localparam scrb_addr_t ADDR_TEMPERATURE_TARGET       = 8'h18;
  localparam scrb_addr_t ADDR_PRESSURE_WINDOW_HIGH     = 8'h19;
  localparam scrb_addr_t ADDR_PRESSURE_WINDOW_LOW      = 8'h1A;
  localparam scrb_addr_t ADDR_TEMPERATURE_WINDOW       = 8'h1B;
  localparam scrb_addr_t ADDR_PRESSURE_MINIMUM_HIGH    = 8'h1C;
  localparam scrb_addr_t ADDR_PRESSURE_MINIMUM_MID     = 8'h1D;
  localparam scrb_addr_t ADDR_PRESSURE_MINIMUM_LOW     = 8'h1E;
  localparam scrb_addr_t ADDR_TEMPERATURE_MINIMUM_HIGH = 8'h1F;
  localparam scrb_addr_t ADDR_TEMPERATURE_MINIMUM_LOW  = 8'h20;
  localparam scrb_addr_t ADDR_PRESSURE_MAXIMUM_HIGH    = 8'h21;
  localparam scrb_addr_t ADDR_PRESSURE_MAXIMUM_MID     = 8'h22;
  localparam scrb_addr_t ADDR_PRESSURE_MAXIMUM_LOW     = 8'h23;
  localparam scrb_addr_t ADDR_TEMPERATURE_MAXIMUM_HIGH = 8'h24;
  localparam scrb_addr_t ADDR_TEMPERATURE_MAXIMUM_LOW  = 8'h25;
  localparam scrb_addr_t ADDR_MODE_OVERSAMPLE_CONTROL  = 8'h26;
  localparam scrb_addr_t ADDR_ACQUISITION_STEP_CONTROL = 8'h27;
  localparam scrb_addr_t ADDR_IRQ_PIN_CONFIG           = 8'h28;
  localparam scrb_addr_t ADDR_IRQ_ENABLES              = 8'h29;
  localparam scrb_addr_t ADDR_IRQ_PIN_ROUTING          = 8'h2A;
  localparam scrb_addr_t ADDR_PRESSURE_USER_OFFSET     = 8'h2B;
  localparam scrb_addr_t ADDR_TEMPERATURE_USER_OFFSET  = 8'h2C;
  localparam scrb_addr_t ADDR_ALTITUDE_USER_OFFSET     = 8'h2D;

  localparam scrb_addr_t ADDR_BANK_FIRST = ADDR_PRESSURE_TARGET_HIGH;
  localparam scrb_addr_t ADDR_BANK_LAST  = ADDR_ALTITUDE_USER_OFFSET;
  localparam scrb_addr_t ADDR_WRAP       = 8'h0C;
  localparam scrb_addr_t ADDR_STEP       = 8'h01;

  // ==========================================================================
  // Control bits that stay writable in the active mode
  // ==========================================================================
  localparam int unsigned BIT_STANDBY_ACTIVE_SELECT = 0;
  localparam int unsigned BIT_ONE_SHOT_TRIGGER      = 1;
  localparam int unsigned BIT_SOFT_RESET            = 2;
  localparam scrb_data_t  MASK_ANY_MODE             = 8'h07;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam scrb_data_t RESET_VALUE = 8'h00;
  localparam scrb_data_t READ_ZERO   = 8'h00;

endpackage : scrb_pkg

// ===== verilog/scrb_register_bank.sv
// Configuration register bank at 16h..2Dh with its own register pointer.
// Assumes a serial front end that turns each bus byte into one-cycle pulses
// on the access port, synchronous to clock; reset is synchronous, active high.
//
// Behaviour
// - The 16-bit pressure target is held in 16h (high byte) and 17h (low byte), read/write, reset 00h.
// - The 16-bit pressure window is held in 19h (high byte) and 1Ah (low byte), read/write.
// - The 20-bit pressure minimum sits in 1Ch..1Eh, bits 19:12, 11:4, then 3:0 in the last byte.
// - The 20-bit pressure maximum sits in 21h..23h, ordered from most to least significant.
// - The 16-bit temperature minimum sits in 1Fh (high) and 20h (low), both host writable.
// - The 16-bit temperature maximum sits in 24h (high) and 25h (low), both host writable.
// - Pressure, temperature and altitude user offsets sit at 2Bh, 2Ch and 2Dh, reset 00h.
// - On multi-byte access the pointer steps by one, and after 2Dh it wraps to 0Ch.
// - Moving from active to standby leaves every register here unchanged.
// - Target, window, minimum and maximum registers accept writes in either mode.
// - Control registers one, three, four and five change only in standby, except three bits of one.
// - Moving from standby to active does not reset any register from 16h to 2Dh.
`timescale 1ns/1ps
`default_nettype none

module scrb_register_bank
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              acc_start,
  input  wire scrb_pkg::scrb_addr_t acc_addr,
  input  wire logic              acc_write,
  input  wire scrb_pkg::scrb_data_t acc_wdata,
  input  wire logic              acc_read,
  output var  scrb_pkg::scrb_data_t acc_rdata,
  output var  logic              acc_rvalid,
  output var  scrb_pkg::scrb_addr_t pointer,
  output var  logic              active_mode,
  output var  scrb_pkg::scrb_data_t mode_oversample_control,
  output var  scrb_pkg::scrb_data_t acquisition_step_control,
  output var  scrb_pkg::scrb_data_t irq_pin_config,
  output var  scrb_pkg::scrb_data_t irq_enables,
  output var  scrb_pkg::scrb_data_t irq_pin_routing
);
  import scrb_pkg::*;

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic in_bank(input scrb_addr_t a);
    in_bank = (a >= ADDR_BANK_FIRST) && (a <= ADDR_BANK_LAST);
  endfunction : in_bank

  function automatic scrb_idx_t bank_index(input scrb_addr_t a);
    scrb_addr_t d;
    d = a - ADDR_BANK_FIRST;
    bank_index = d[IDX_W-1:0];
  endfunction : bank_index

  function automatic scrb_addr_t step_pointer(input scrb_addr_t a);
    if (a == ADDR_BANK_LAST)
      step_pointer = ADDR_WRAP;
    else
      step_pointer = a + ADDR_STEP;
  endfunction : step_pointer

  // Control registers one, three, four and five are standby-only.
  function automatic logic standby_only(input scrb_addr_t a);
    standby_only = (a == ADDR_MODE_OVERSAMPLE_CONTROL) ||
                   (a == ADDR_IRQ_PIN_CONFIG) ||
                   (a == ADDR_IRQ_ENABLES) ||
                   (a == ADDR_IRQ_PIN_ROUTING);
  endfunction : standby_only

  // ==========================================================================
  // Storage
  // ==========================================================================
  // One byte per address; the value and multi-byte layout of targets, windows,
  // extremes and offsets are exactly as the host writes them.
  scrb_data_t bank [BANK_N];

  scrb_data_t next_byte;
  logic       write_hit;
  scrb_idx_t  write_idx;
  logic       ctrl1_hit;

  assign write_hit = acc_write && !acc_start && in_bank(pointer);
  assign write_idx = bank_index(pointer);
  assign ctrl1_hit = pointer == ADDR_MODE_OVERSAMPLE_CONTROL;

  // Merge rule for the write data: in active mode only the three any-mode bits
  // of control register one may change; other standby-only registers keep all.
  always_comb
  begin
    next_byte = acc_wdata;
    if (active_mode && standby_only(pointer))
    begin
      if (ctrl1_hit)
        next_byte = (bank[write_idx] & ~MASK_ANY_MODE) | (acc_wdata & MASK_ANY_MODE);
      else
        next_byte = bank[write_idx];
    end
  end

  // ==========================================================================
  // Register writes
  // ==========================================================================
  // Only the reset input clears the bank; the mode bit never does, so mode
  // changes in either direction leave contents as last written.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < BANK_N; i++)
        bank[i] <= RESET_VALUE;
    end
    else if (write_hit)
    begin
      bank[write_idx] <= next_byte;
    end
  end

  // ==========================================================================
  // Register pointer
  // ==========================================================================
  // A start pulse loads the pointer and takes priority over any byte pulse
  // in the same cycle, which is then dropped.
  always_ff @(posedge clock)
  begin
    if (rst)
      pointer <= ADDR_WRAP;
    else if (acc_start)
      pointer <= acc_addr;
    else if (acc_write || acc_read)
      pointer <= step_pointer(pointer);
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Addresses outside this bank answer 00h; the lower map lives elsewhere.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      acc_rdata  <= READ_ZERO;
      acc_rvalid <= 1'b0;
    end
    else
    begin
      acc_rvalid <= acc_read && !acc_start;
      if (acc_read && !acc_start)
        acc_rdata <= in_bank(pointer) ? bank[bank_index(pointer)] : READ_ZERO;
    end
  end

  // ==========================================================================
  // Control outputs
  // ==========================================================================
  // Mirrors are registered copies, so they lag the bank by one cycle.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      active_mode              <= 1'b0;
      mode_oversample_control  <= RESET_VALUE;
      acquisition_step_control <= RESET_VALUE;
      irq_pin_config           <= RESET_VALUE;
      irq_enables              <= RESET_VALUE;
      irq_pin_routing          <= RESET_VALUE;
    end
    else
    begin
      active_mode <= bank[bank_index(ADDR_MODE_OVERSAMPLE_CONTROL)][BIT_STANDBY_ACTIVE_SELECT];
      mode_oversample_control  <= bank[bank_index(ADDR_MODE_OVERSAMPLE_CONTROL)];
      acquisition_step_control <= bank[bank_index(ADDR_ACQUISITION_STEP_CONTROL)];
      irq_pin_config           <= bank[bank_index(ADDR_IRQ_PIN_CONFIG)];
      irq_enables              <= bank[bank_index(ADDR_IRQ_ENABLES)];
      irq_pin_routing          <= bank[bank_index(ADDR_IRQ_PIN_ROUTING)];
    end
  end

endmodule : scrb_register_bank

`default_nettype wire

// ===== tb/scrb_bank_assertions.sv
// Checker for pointer, read answer and control locks of the bank.
// Bound to scrb_register_bank; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module scrb_bank_assertions
  import scrb_pkg::*;
(
  input wire logic       clock, rst, acc_start, acc_write, acc_read, acc_rvalid, active_mode,
  input wire scrb_addr_t acc_addr, pointer,
  input wire scrb_data_t acc_wdata, acc_rdata, mode_oversample_control, irq_pin_config
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // A byte pulse sharing its cycle with a start is dropped, so only these count.
  wire logic wr = acc_write && !acc_start;
  wire logic rd = acc_read && !acc_start;
  chk_start_load: assert property (acc_start |=> pointer == $past(acc_addr))
    else $error("pointer not loaded on start");
  chk_step_pointer: assert property (
    (wr || rd) && pointer inside {[8'h16:8'h2C]} |=> pointer == $past(pointer) + 8'h01)
    else $error("pointer did not step");
  chk_wrap_pointer: assert property (
    (wr || rd) && pointer == 8'h2D |=> pointer == 8'h0C) else $error("pointer did not wrap");
  chk_read_answer: assert property (1'b1 |=> acc_rvalid == $past(rd))
    else $error("read valid not one cycle after read");
  chk_read_outside: assert property (
    rd && !(pointer inside {[8'h16:8'h2D]}) |=> acc_rdata == 8'h00) else $error("outside read");
  chk_locked_irq: assert property (
    active_mode && wr && pointer == 8'h28 |=> ##1 $stable(irq_pin_config))
    else $error("locked register changed");
  chk_any_mode_bits: assert property (
    active_mode && wr && pointer == 8'h26 |=> ##1 $stable(mode_oversample_control[7:3]))
    else $error("locked control bits changed");
  chk_standby_ctrl: assert property (
    !active_mode && wr && pointer == 8'h26 |=> ##1 mode_oversample_control == $past(acc_wdata, 2)
    && active_mode == mode_oversample_control[0]) else $error("control write not mirrored");
  cover property (wr && pointer == 8'h2D);
  cover property (active_mode && wr && pointer == 8'h28);
  cover property (rd && pointer == 8'h0C);
endmodule : scrb_bank_assertions
bind scrb_register_bank scrb_bank_assertions u_chk (.clock(clock), .rst(rst),
  .acc_start(acc_start), .acc_write(acc_write), .acc_read(acc_read), .acc_rvalid(acc_rvalid),
  .active_mode(active_mode), .acc_addr(acc_addr), .pointer(pointer), .acc_wdata(acc_wdata),
  .acc_rdata(acc_rdata), .mode_oversample_control(mode_oversample_control),
  .irq_pin_config(irq_pin_config));
`default_nettype wire

// ===== tb/scrb_host_model.sv
// Host model: one access-port pulse per call.
// Assumes calls come from one bench process.
`timescale 1ns/1ps
`default_nettype none
module scrb_host_model
  import scrb_pkg::*;
(
  input  wire logic       clock,
  output var  logic       acc_start,
  output var  logic       acc_write,
  output var  logic       acc_read,
  output var  scrb_addr_t acc_addr,
  output var  scrb_data_t acc_wdata,
  input  wire scrb_data_t acc_rdata,
  input  wire logic       acc_rvalid
);
  initial {acc_start, acc_write, acc_read, acc_addr, acc_wdata} = '0;
  // Idle address and data are inverted so a stale byte is never mistaken for a live one.
  task automatic xfer(input logic s, w, r, input scrb_data_t d, output scrb_data_t q,
                      output logic v);
    @(posedge clock) #1;
    {acc_start, acc_write, acc_read} = {s, w, r};
    {acc_addr, acc_wdata} = {d, d};
    @(posedge clock) #1;
    q = acc_rdata;
    v = acc_rvalid;
    {acc_start, acc_write, acc_read} = 3'b000;
    {acc_addr, acc_wdata} = ~{d, d};
  endtask : xfer
endmodule : scrb_host_model
`default_nettype wire

// ===== tb/scrb_register_bank_tb.sv
// Bench: host model drives bursts, a local copy predicts every read.
// Assumes package, bank, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module scrb_register_bank_tb;
  import scrb_pkg::*;
  logic       clock, rst, acc_start, acc_write, acc_read, acc_rvalid, active_mode, v;
  scrb_addr_t acc_addr, pointer;
  scrb_data_t acc_wdata, acc_rdata, mode_oversample_control, irq_pin_config, q;
  scrb_data_t acquisition_step_control, irq_enables, irq_pin_routing;
  scrb_data_t mdl [BANK_N];
  int         mismatches = 0;
  int         samples_checked = 0;
  scrb_register_bank uut (.clock(clock), .rst(rst), .acc_start(acc_start), .acc_addr(acc_addr),
    .acc_write(acc_write), .acc_wdata(acc_wdata), .acc_read(acc_read), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .pointer(pointer), .active_mode(active_mode),
    .mode_oversample_control(mode_oversample_control),
    .acquisition_step_control(acquisition_step_control),
    .irq_pin_config(irq_pin_config), .irq_enables(irq_enables),
    .irq_pin_routing(irq_pin_routing));
  scrb_host_model u_host (.clock(clock), .acc_start(acc_start), .acc_addr(acc_addr),
    .acc_write(acc_write), .acc_wdata(acc_wdata), .acc_read(acc_read),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // One byte write, optionally after a start; the copy applies the active-mode locks.
  task automatic wr(input scrb_addr_t a, input scrb_data_t d, input logic s);
    int i;
    i = int'(a - ADDR_BANK_FIRST);
    if (s)
      u_host.xfer(1'b1, 1'b0, 1'b0, a, q, v);
    u_host.xfer(1'b0, 1'b1, 1'b0, d, q, v);
    if (mdl[16][0] && a == ADDR_MODE_OVERSAMPLE_CONTROL)
      mdl[i] = (mdl[i] & ~MASK_ANY_MODE) | (d & MASK_ANY_MODE);
    else if (!mdl[16][0] || !(a inside {[ADDR_IRQ_PIN_CONFIG:ADDR_IRQ_PIN_ROUTING]}))
      mdl[i] = d;
  endtask : wr
  // Burst read of the whole bank plus one byte past the wrap.
  task automatic check_all();
    u_host.xfer(1'b1, 1'b0, 1'b0, ADDR_BANK_FIRST, q, v);
    for (int i = 0; i <= BANK_N; i++)
    begin
      u_host.xfer(1'b0, 1'b0, 1'b1, 8'h00, q, v);
      `CHK("rvalid", 1'b1, v)
      `CHK("byte", (i < BANK_N) ? mdl[i] : READ_ZERO, q)
    end
    `CHK("pointer", 8'h0D, pointer)
  endtask : check_all
  initial
  begin
    rst = 1'b1;
    foreach (mdl[i]) mdl[i] = RESET_VALUE;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    check_all();
    for (int i = 0; i < BANK_N; i++) wr(scrb_addr_t'(8'h16 + i), 8'(i * 8 + 8), i == 0);
    `CHK("wrap", ADDR_WRAP, pointer)
    check_all();
    `CHK("mirror", mdl[18], irq_pin_config)
    `CHK("mirror_en", mdl[19], irq_enables)
    `CHK("mirror_route", mdl[20], irq_pin_routing)
    `CHK("mirror_step", mdl[17], acquisition_step_control)
    wr(ADDR_MODE_OVERSAMPLE_CONTROL, 8'h01, 1'b1);
    wr(ADDR_PRESSURE_TARGET_HIGH, 8'hA5, 1'b1);
    wr(ADDR_IRQ_PIN_CONFIG, 8'hFF, 1'b1);
    wr(ADDR_IRQ_ENABLES, 8'hFF, 1'b1);
    wr(ADDR_IRQ_PIN_ROUTING, 8'hFF, 1'b1);
    wr(ADDR_ACQUISITION_STEP_CONTROL, 8'h5A, 1'b1);
    wr(ADDR_MODE_OVERSAMPLE_CONTROL, 8'hFF, 1'b1);
    check_all();
    `CHK("active", 1'b1, active_mode)
    `CHK("locked", mdl[18], irq_pin_config)
    `CHK("locked_en", mdl[19], irq_enables)
    `CHK("locked_route", mdl[20], irq_pin_routing)
    `CHK("step_any_mode", mdl[17], acquisition_step_control)
    wr(ADDR_MODE_OVERSAMPLE_CONTROL, 8'h00, 1'b1);
    check_all();
    `CHK("standby", 1'b0, active_mode)
    close_out();
  end
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
endmodule : scrb_register_bank_tb
`default_nettype wire
